// ==== bench/gaf_isa_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host on the I/O bus
// ****************************************
module gaf_isa_host (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [7:0] io_data_in
);
  initial begin
    io_addr = 16'hFFFF;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_data_in = 8'h00;
  end
  // Address leads the command so the synced copy has settled
  task automatic cmd(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d, input int n);
    @(posedge clk);
    io_addr <= a;
    io_data_in <= d;
    repeat (4) @(posedge clk);
    io_wr_n <= !w;
    io_rd_n <= !r;
    repeat (n) @(posedge clk);
  endtask
  // Released data shows the inverse, so a late capture is caught
  task automatic rel;
    @(posedge clk);
    io_wr_n <= 1'b1;
    io_rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    io_data_in <= ~io_data_in;
    io_addr <= 16'hFFFF;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/gaf_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module gaf_monitor #(
  parameter int unsigned REF_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic io_rd_n,
  input wire logic io_data_oe,
  input wire logic [11:0] gpio_oe,
  input wire logic [15:0] irq_out,
  input wire logic [15:0] irq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_reset_quiet: assert property (
    !$past(rstn) |-> gpio_oe == 12'h000 && irq_oe == 16'h0000 && !io_data_oe && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  a_spare_zero: assert property (
    $past(reg_rd) && $past(reg_addr) inside {8'h68, 8'h69, 8'h73} |-> reg_rdata == 8'h00)
    else $error("spare register not zero");
  a_base_top_zero: assert property (
    $past(reg_rd) && $past(reg_addr) inside {8'h60, 8'h62, 8'h64, 8'h66} |-> reg_rdata[7:4] == 4'h0)
    else $error("base top nibble not zero");
  a_blink_reserved: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h71 |-> !reg_rdata[5] && !reg_rdata[0])
    else $error("blink reserved bits set");
  a_irq_bad_lines: assert property (
    (irq_out & 16'hE005) == 16'h0000 && (irq_oe & 16'hE005) == 16'h0000)
    else $error("invalid interrupt line active");
  a_pin_reg_back: assert property (
    $past(reg_wr, 2) && $past(reg_rd) && $past(reg_addr) == $past(reg_addr, 2)
    && $past(reg_addr) inside {8'hF0, 8'hF4, 8'hF5} |-> reg_rdata == $past(reg_wdata, 2))
    else $error("pin register readback wrong");
  a_base_hi_back: assert property (
    $past(reg_wr, 2) && $past(reg_rd) && $past(reg_addr) == $past(reg_addr, 2)
    && $past(reg_addr) inside {8'h60, 8'h66} |-> reg_rdata == ($past(reg_wdata, 2) & 8'h0F))
    else $error("base high readback wrong");
  a_io_oe_cause: assert property (
    $past(io_rd_n, 3) |-> !io_data_oe)
    else $error("data driven without read");
endmodule
bind gaf_top gaf_monitor #(.REF_CYCLES(REF_CYCLES)) u_gaf_monitor (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_rd_n(io_rd_n), .io_data_oe(io_data_oe),
  .gpio_oe(gpio_oe), .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire

// ==== bench/gpio_altfunc_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Testbench
// ****************************************
module gpio_altfunc_config_tb;
  localparam int unsigned REF = 4;
  localparam logic [7:0] AL [26] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69,
    8'h70, 8'h71, 8'h72, 8'h73, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF8, 8'hF9, 8'hFA,
    8'h50, 8'hE0};
  logic clk, rstn, reg_wr, reg_rd, io_rd_n, io_wr_n, io_data_oe, on, lvl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, io_data_in, io_data_out, v, d;
  logic [15:0] io_addr, irq_out, irq_oe, e;
  logic [11:0] gpio_in, gpio_out, gpio_oe, base, pol, o;
  int failures, n_compared, k, n;
  gaf_top #(.REF_CYCLES(REF)) u_gaf_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .irq_out(irq_out), .irq_oe(irq_oe));
  gaf_isa_host u_gaf_isa_host (.clk(clk), .io_addr(io_addr), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
    .io_data_in(io_data_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h60, 8'h62, 8'h64, 8'h66, 8'hF8, 8'hF9, 8'hFA: return 8'h0F;
      8'h71: return 8'hDE;
      8'h61, 8'h63, 8'h65, 8'h67, 8'h70, 8'h72, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  // Write leaves its strobe up; the next task's edge ends it, so transfers run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, x);
  endtask
  task automatic idle;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] x);
    u_gaf_isa_host.cmd(a, w, !w, x, $urandom_range(9, 6));
    @(negedge clk);
  endtask
  task automatic done;
    u_gaf_isa_host.rel();
    @(negedge clk);
  endtask
  task automatic edg(output int c);
    logic p;
    p = gpio_out[2];
    c = 0;
    while (gpio_out[2] === p && c < 2000) begin
      @(negedge clk);
      c++;
    end
  endtask
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, rstn, gpio_in} = '0;
    failures = 0;
    n_compared = 0;
    v = 8'($urandom(25450));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (AL[i]) rd(AL[i], 8'h00);
    for (int p = 0; p < 2; p++) foreach (AL[i]) begin
      v = p ? 8'($urandom) : 8'hFF;
      wr(AL[i], v);
      rd(AL[i], v & msk(AL[i]));
    end
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(8'hF5, 8'h00);
    $display("registers done");
    base = 12'($urandom);
    pol = 12'($urandom);
    d = 8'($urandom);
    v = 8'($urandom);
    wr(8'h66, {4'h0, base[11:8]});
    wr(8'h67, base[7:0]);
    wr(8'hF0, pol[7:0]);
    wr(8'hF8, {4'h0, pol[11:8]});
    wr(8'hF4, 8'hFF);
    wr(8'hF9, 8'h0F);
    wr(8'hF5, 8'h00);
    wr(8'hFA, 8'h00);
    idle();
    io(base, 1'b1, d);
    done();
    io(base + 12'h001, 1'b1, v);
    done();
    chk(gpio_out, {v[3:0], d} ^ pol);
    chk(gpio_oe, 12'hFFF);
    wr(8'hF5, 8'hFF);
    wr(8'hFA, 8'h0F);
    idle();
    chk(gpio_oe, 12'h000);
    @(posedge clk);
    gpio_in <= 12'($urandom);
    io(base, 1'b0, 8'h00);
    chk(io_data_out, gpio_in[7:0] ^ pol[7:0]);
    chk(io_data_oe, 1'b1);
    done();
    io(base + 12'h001, 1'b0, 8'h00);
    chk(io_data_out[3:0], gpio_in[11:8] ^ pol[11:8]);
    done();
    wr(8'hF6, 8'h30);
    idle();
    io(base, 1'b0, 8'h00);
    chk(io_data_out[3:0], gpio_in[11:8] ^ pol[11:8]);
    done();
    io(base + 12'h001, 1'b0, 8'h00);
    chk(io_data_oe, 1'b0);
    done();
    $display("plain port done");
    base = 12'($urandom) & 12'h7F8;
    wr(8'hF6, 8'h07);
    wr(8'hF4, 8'h00);
    wr(8'hF0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(gaf_pkg::IDX_CS_HI[i], {4'h0, base[11:8]});
      wr(gaf_pkg::IDX_CS_LO[i], base[7:0]);
    end
    for (int s = 0; s < 4; s++) for (int q = 0; q < 4; q++) begin
      k = (s + q) % 3;
      wr(gaf_pkg::IDX_CS_CTRL[k], {2'(s), 2'(q), 4'(2 * k + 1)});
      idle();
      for (int m = 0; m < 4; m++) begin
        o = m[1] ? (12'h001 << s) : (12'h001 << s) - 12'h001;
        on = !m[1] && (q == 0 || q == 3 || (q == 1 && !m[0]) || (q == 2 && m[0]));
        io(base + o, m[0], 8'h5A);
        chk(gpio_out[k], !on);
        chk(gpio_oe[k], 1'b1);
        if (on) chk(gpio_out[3], 1'b0);
        done();
      end
    end
    $display("chip strobes done");
    wr(8'hF1, 8'h00);
    wr(8'hF2, 8'h00);
    wr(8'hF3, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(8'h71, {2'(r), 1'b0, 4'h5, 1'b0});
      idle();
      edg(n);
      repeat (2) begin
        edg(n);
        chk(16'(n), 16'(REF << (2 * r)));
      end
    end
    $display("blink done");
    wr(8'h71, 8'h00);
    for (int c = 0; c < 16; c++) begin
      lvl = 1'($urandom);
      e = (c == 1 || (c >= 3 && c <= 12)) ? 16'h0001 << c : 16'h0000;
      @(posedge clk);
      gpio_in <= {7'h00, lvl, 4'h0};
      wr(8'h70, {4'h9, 4'(c)});
      wr(8'h72, 8'h00);
      wr(8'hF6, c[0] ? 8'h40 : 8'h00);
      idle();
      chk(irq_oe, (lvl || !c[0]) ? e : 16'h0000);
      chk(irq_out, lvl ? e : 16'h0000);
      wr(8'h72, {4'h9, 4'(c)});
      wr(8'h70, 8'h00);
      wr(8'hF6, 8'h80);
      idle();
      chk(irq_oe, lvl ? e : 16'h0000);
      chk(irq_out, lvl ? e : 16'h0000);
    end
    $display("steering done");
    close_out();
  end
  initial begin
    #(60000 * 5);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire

// ==== core/gaf_blink.sv ====
`timescale 1ns/1ps
`default_nettype none
module gaf_blink #(
  parameter int unsigned REF_CYCLES = gaf_pkg::REF_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] rate,
  output logic wave
);

  localparam int unsigned REF_W = $clog2(REF_CYCLES + 1);
  localparam logic [REF_W-1:0] REF_LAST = REF_W'(REF_CYCLES - 1);

  typedef struct packed {
    logic [REF_W-1:0] ref_cnt;
    logic [gaf_pkg::BLINK_DIV_BITS-1:0] div;
    logic wave;
  } gaf_blink_s;

  gaf_blink_s q;
  gaf_blink_s n;

  always_comb begin
    n = q;
    // Reference ticks at twice the fastest rate; each divider bit halves it
    if (q.ref_cnt == REF_LAST) begin
      n.ref_cnt = '0;
      n.div = q.div + 1'b1;
    end else begin
      n.ref_cnt = q.ref_cnt + 1'b1;
    end
    n.wave = q.div[{rate, 1'b0}]; // [R7] [R18]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign wave = q.wave;

endmodule
`default_nettype wire

// ==== core/gaf_chipsel.sv ====
`timescale 1ns/1ps
`default_nettype none
module gaf_chipsel (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  gaf_cs_if.dec cs
);

  typedef struct packed {
    logic strobe;
  } gaf_cs_s;

  gaf_cs_s q;
  gaf_cs_s n;
  logic [15:0] mask;
  logic match;

  always_comb begin
    n = q;
    // Span 1/2/4/8 ports: low address bits ignored
    mask = ~((16'h0001 << cs.span) - 16'h0001);
    match = (io_addr & mask) == ({gaf_pkg::ADDR_TOP_ZERO, cs.base} & mask);
    case (cs.qual)
      gaf_pkg::QUAL_ADDR: n.strobe = match;
      gaf_pkg::QUAL_RD: n.strobe = match & io_rd;
      gaf_pkg::QUAL_WR: n.strobe = match & io_wr;
      default: n.strobe = match & (io_rd | io_wr);
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cs.strobe = q.strobe;

endmodule
`default_nettype wire

// ==== core/gaf_cs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface gaf_cs_if;
  logic [11:0] base;
  logic [1:0] span;
  logic [1:0] qual;
  logic strobe;
  modport cfg (output base, output span, output qual, input strobe);
  modport dec (input base, input span, input qual, output strobe);
endinterface
`default_nettype wire

// ==== core/gaf_pkg.sv ====
package gaf_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] IDX_CS_HI [3] = '{8'h60, 8'h62, 8'h64};
  localparam logic [7:0] IDX_CS_LO [3] = '{8'h61, 8'h63, 8'h65};
  localparam logic [7:0] IDX_CS_CTRL [3] = '{8'hF1, 8'hF2, 8'hF3};
  localparam logic [7:0] IDX_SIO_HI = 8'h66;
  localparam logic [7:0] IDX_SIO_LO = 8'h67;
  localparam logic [7:0] IDX_SPARE_A = 8'h68;
  localparam logic [7:0] IDX_SPARE_B = 8'h69;
  localparam logic [7:0] IDX_IRQ1 = 8'h70;
  localparam logic [7:0] IDX_BLINK = 8'h71;
  localparam logic [7:0] IDX_IRQ2 = 8'h72;
  localparam logic [7:0] IDX_SPARE_C = 8'h73;
  localparam logic [7:0] IDX_POL_LO = 8'hF0;
  localparam logic [7:0] IDX_FUNC_LO = 8'hF4;
  localparam logic [7:0] IDX_DIR_LO = 8'hF5;
  localparam logic [7:0] IDX_SHARE = 8'hF6;
  localparam logic [7:0] IDX_POL_HI = 8'hF8;
  localparam logic [7:0] IDX_FUNC_HI = 8'hF9;
  localparam logic [7:0] IDX_DIR_HI = 8'hFA;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] HI_WR_MASK = 8'h0F;
  localparam logic [7:0] BLINK_WR_MASK = 8'hDE;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam int unsigned SPAN_MSB = 7;
  localparam int unsigned SPAN_LSB = 6;
  localparam int unsigned QUAL_MSB = 5;
  localparam int unsigned QUAL_LSB = 4;
  localparam int unsigned LOC_MSB = 3;
  localparam int unsigned LOC_LSB = 0;
  localparam int unsigned ROUTE_LOC_MSB = 7;
  localparam int unsigned ROUTE_LOC_LSB = 4;
  localparam int unsigned ROUTE_IRQ_MSB = 3;
  localparam int unsigned ROUTE_IRQ_LSB = 0;
  localparam int unsigned RATE_MSB = 7;
  localparam int unsigned RATE_LSB = 6;
  localparam int unsigned BLINK_LOC_MSB = 4;
  localparam int unsigned BLINK_LOC_LSB = 1;
  localparam int unsigned SHARE2_BIT = 7;
  localparam int unsigned SHARE1_BIT = 6;
  localparam int unsigned SINGLE_GRP_BIT = 5;
  localparam int unsigned SINGLE_PORT_BIT = 4;
  localparam logic [15:0] SIO_HI_OFS = 16'h0001;
  localparam logic [3:0] ADDR_TOP_ZERO = 4'h0;

  // ****************************************
  // Encodings
  // ****************************************
  localparam int unsigned NUM_PINS = 12;
  localparam int unsigned NUM_IRQ = 16;
  localparam logic [3:0] LOC_NONE = 4'h0;
  localparam logic [3:0] LOC_HIGH_LAST = 4'h8;
  localparam logic [3:0] PIN_HIGH_OFS = 4'h7;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [3:0] IRQ_BAD = 4'h2;
  localparam logic [3:0] IRQ_LAST = 4'hC;
  localparam logic [1:0] QUAL_ADDR = 2'h0;
  localparam logic [1:0] QUAL_RD = 2'h1;
  localparam logic [1:0] QUAL_WR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FAST_BLINK_HZ = 16;
  localparam int unsigned REF_CYCLES = CLK_HZ / (2 * FAST_BLINK_HZ);
  localparam int unsigned BLINK_DIV_BITS = 7;

  typedef struct packed {
    logic hit;
    logic [3:0] pin;
  } gaf_pinsel_s;

  // Odd codes walk pins 0-7, even codes 2-8 walk pins 8-11
  function automatic gaf_pinsel_s gaf_pin_of(input logic [3:0] code);
    gaf_pinsel_s s;
    s.hit = 1'b0;
    s.pin = 4'h0;
    if (code[0]) begin
      s.hit = 1'b1;
      s.pin = {1'b0, code[3:1]};
    end else if (code != LOC_NONE && code <= LOC_HIGH_LAST) begin
      s.hit = 1'b1;
      s.pin = {1'b0, code[3:1]} + PIN_HIGH_OFS;
    end
    return s;
  endfunction

  function automatic logic gaf_irq_ok(input logic [3:0] code);
    return code != IRQ_NONE && code != IRQ_BAD && code <= IRQ_LAST;
  endfunction

endpackage

// ==== core/gaf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
//Contract
// [R1] Chip-select bases, twelve writable bits, top zero
// [R2] Control bits 7-6 span, 3-0 pin location
// [R3] Bits 5-4 qualify strobe with read/write
// [R4] Plain I/O base pair, twelve writable bits
// [R5] Steering one: pin 7-4, IRQ 3-0
// [R6] Steering two: same layout, same invalid codes
// [R7] Blink rates 16, 4, 1, quarter hertz
// [R8] Blink pin in bits 4-1, others reserved; code takes the rate from bits 7-6 and reserves only bits 5 and 0
// [R9] Polarity bit inverts matching pin
// [R10] Function bit one selects plain I/O
// [R11] Direction bit one makes pin input
// [R12] Spare registers read zero, do nothing
// [R13] All configuration resets to zero
// [R14] Location zero or unlisted selects no pin
// [R15] Share bits 7 and 6 per steering
// [R16] Data ports at base and base plus one
// [R17] Single-port mode, bit 5 picks group
// [R18] Blink is near-square divided reference
// [R19] Inversion applies to reads and writes
module gaf_top #(
  parameter int unsigned REF_CYCLES = gaf_pkg::REF_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] io_data_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe,
  input wire logic [11:0] gpio_in,
  output logic [11:0] gpio_out,
  output logic [11:0] gpio_oe,
  output logic [15:0] irq_out,
  output logic [15:0] irq_oe
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0][7:0] cs_hi;
    logic [2:0][7:0] cs_lo;
    logic [2:0][7:0] cs_ctrl;
    logic [7:0] sio_hi;
    logic [7:0] sio_lo;
    logic [7:0] irq1;
    logic [7:0] blink;
    logic [7:0] irq2;
    logic [7:0] pol_lo;
    logic [7:0] func_lo;
    logic [7:0] dir_lo;
    logic [7:0] share;
    logic [3:0] pol_hi;
    logic [3:0] func_hi;
    logic [3:0] dir_hi;
    logic [11:0] sio_data;
    logic [15:0] addr_m;
    logic [15:0] addr_s;
    logic rd_m;
    logic rd_s;
    logic wr_m;
    logic wr_s;
    logic wr_d;
    logic [7:0] din_m;
    logic [7:0] din_s;
    logic [11:0] pin_m;
    logic [11:0] pin_s;
    logic fcg;
    logic [7:0] rdata;
    logic [7:0] io_dout;
    logic io_doe;
    logic [11:0] gpio_out;
    logic [11:0] gpio_oe;
    logic [15:0] irq_out;
    logic [15:0] irq_oe;
  } gaf_top_s;

  gaf_top_s q;
  gaf_top_s n;
  logic [7:0] rd_val;
  logic blink_wave;
  logic [11:0] pol;
  logic [11:0] func;
  logic [11:0] dir;
  logic [11:0] sio_rd;
  logic [11:0] sio_base;
  logic [15:0] sio_addr;
  logic hit_lo;
  logic hit_hi;
  logic [2:0] cs_strobe;
  logic src1;
  logic src2;

  // One decoder per chip strobe; each sees the synced bus copy
  gaf_cs_if cs_bus [3] ();

  // ****************************************
  // Chip-select decoders
  // ****************************************
  for (genvar g = 0; g < 3; g++) begin : g_cs
    assign cs_bus[g].base = {q.cs_hi[g][3:0], q.cs_lo[g]}; // [R1]
    assign cs_bus[g].span = q.cs_ctrl[g][gaf_pkg::SPAN_MSB:gaf_pkg::SPAN_LSB]; // [R2]
    assign cs_bus[g].qual = q.cs_ctrl[g][gaf_pkg::QUAL_MSB:gaf_pkg::QUAL_LSB]; // [R3]
    assign cs_strobe[g] = cs_bus[g].strobe;
    gaf_chipsel u_cs (
      .clk(clk),
      .rstn(rstn),
      .io_addr(q.addr_s),
      .io_rd(q.rd_s),
      .io_wr(q.wr_s),
      .cs(cs_bus[g])
    );
  end

  gaf_blink #(
    .REF_CYCLES(REF_CYCLES)
  ) u_blink (
    .clk(clk),
    .rstn(rstn),
    .rate(q.blink[gaf_pkg::RATE_MSB:gaf_pkg::RATE_LSB]),
    .wave(blink_wave)
  );

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    rd_val = gaf_pkg::REG_RESET;
    for (int i = 0; i < 3; i++) begin
      if (reg_addr == gaf_pkg::IDX_CS_HI[i]) begin
        rd_val = q.cs_hi[i];
      end
      if (reg_addr == gaf_pkg::IDX_CS_LO[i]) begin
        rd_val = q.cs_lo[i];
      end
      if (reg_addr == gaf_pkg::IDX_CS_CTRL[i]) begin
        rd_val = q.cs_ctrl[i];
      end
    end
    case (reg_addr)
      gaf_pkg::IDX_SIO_HI: rd_val = q.sio_hi;
      gaf_pkg::IDX_SIO_LO: rd_val = q.sio_lo;
      gaf_pkg::IDX_IRQ1: rd_val = q.irq1;
      gaf_pkg::IDX_BLINK: rd_val = q.blink;
      gaf_pkg::IDX_IRQ2: rd_val = q.irq2;
      gaf_pkg::IDX_POL_LO: rd_val = q.pol_lo;
      gaf_pkg::IDX_FUNC_LO: rd_val = q.func_lo;
      gaf_pkg::IDX_DIR_LO: rd_val = q.dir_lo;
      gaf_pkg::IDX_SHARE: rd_val = q.share;
      gaf_pkg::IDX_POL_HI: rd_val = {gaf_pkg::NIB_RESET, q.pol_hi};
      gaf_pkg::IDX_FUNC_HI: rd_val = {gaf_pkg::NIB_RESET, q.func_hi};
      gaf_pkg::IDX_DIR_HI: rd_val = {gaf_pkg::NIB_RESET, q.dir_hi};
      default: begin
        // Spare and unmapped indices keep whatever the loop gave, else zero
      end
    endcase
  end

  assign pol = {q.pol_hi, q.pol_lo};
  assign func = {q.func_hi, q.func_lo};
  assign dir = {q.dir_hi, q.dir_lo};
  assign sio_rd = q.pin_s ^ pol; // [R19]
  assign sio_base = {q.sio_hi[3:0], q.sio_lo}; // [R4]
  assign sio_addr = {gaf_pkg::ADDR_TOP_ZERO, sio_base};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    gaf_pkg::gaf_pinsel_s sel;
    logic single;
    logic grp;
    logic lvl;
    sel = '0;
    single = 1'b0;
    grp = 1'b0;
    lvl = 1'b0;
    n = q;

    // Commands are inverted ahead of the flops so the reset value means idle
    // Pin-side inputs; address and data may skew across the two stages,
    // so the host must hold them steady around the command edge
    n.addr_m = io_addr;
    n.addr_s = q.addr_m;
    n.rd_m = ~io_rd_n;
    n.rd_s = q.rd_m;
    n.wr_m = ~io_wr_n;
    n.wr_s = q.wr_m;
    n.wr_d = q.wr_s;
    n.din_m = io_data_in;
    n.din_s = q.din_m;
    n.pin_m = gpio_in;
    n.pin_s = q.pin_m;

    if (reg_wr) begin
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == gaf_pkg::IDX_CS_HI[i]) begin
          n.cs_hi[i] = reg_wdata & gaf_pkg::HI_WR_MASK; // [R1]
        end
        if (reg_addr == gaf_pkg::IDX_CS_LO[i]) begin
          n.cs_lo[i] = reg_wdata; // [R1]
        end
        if (reg_addr == gaf_pkg::IDX_CS_CTRL[i]) begin
          n.cs_ctrl[i] = reg_wdata; // [R2] [R3]
        end
      end
      case (reg_addr)
        gaf_pkg::IDX_SIO_HI: n.sio_hi = reg_wdata & gaf_pkg::HI_WR_MASK; // [R4]
        gaf_pkg::IDX_SIO_LO: n.sio_lo = reg_wdata; // [R4]
        gaf_pkg::IDX_IRQ1: n.irq1 = reg_wdata; // [R5]
        gaf_pkg::IDX_BLINK: n.blink = reg_wdata & gaf_pkg::BLINK_WR_MASK; // [R8]
        gaf_pkg::IDX_IRQ2: n.irq2 = reg_wdata; // [R6]
        gaf_pkg::IDX_POL_LO: n.pol_lo = reg_wdata; // [R9]
        gaf_pkg::IDX_FUNC_LO: n.func_lo = reg_wdata; // [R10]
        gaf_pkg::IDX_DIR_LO: n.dir_lo = reg_wdata; // [R11]
        gaf_pkg::IDX_SHARE: n.share = reg_wdata; // [R15] [R17]
        gaf_pkg::IDX_POL_HI: n.pol_hi = reg_wdata[3:0];
        gaf_pkg::IDX_FUNC_HI: n.func_hi = reg_wdata[3:0];
        gaf_pkg::IDX_DIR_HI: n.dir_hi = reg_wdata[3:0];
        default: begin
          // Spare indices take no write
        end
      endcase
    end
    n.rdata = reg_rd ? rd_val : gaf_pkg::REG_RESET; // [R12]

    // ****************************************
    // Plain I/O data ports
    // ****************************************
    single = q.share[gaf_pkg::SINGLE_PORT_BIT];
    grp = q.share[gaf_pkg::SINGLE_GRP_BIT];
    if (single) begin
      hit_lo = (q.addr_s == sio_addr) && !grp; // [R17]
      hit_hi = (q.addr_s == sio_addr) && grp; // [R17]
    end else begin
      hit_lo = q.addr_s == sio_addr; // [R16]
      // Base plus one may carry into bit 12; that address still decodes
      hit_hi = q.addr_s == sio_addr + gaf_pkg::SIO_HI_OFS; // [R16]
    end
    n.io_doe = q.rd_s & (hit_lo | hit_hi);
    n.io_dout = hit_lo ? sio_rd[7:0] : {gaf_pkg::NIB_RESET, sio_rd[11:8]}; // [R19]
    // Store once per command, so a long write never latches skewed data
    if (q.wr_s && !q.wr_d) begin
      if (hit_lo) begin
        n.sio_data[7:0] = q.din_s;
      end
      if (hit_hi) begin
        n.sio_data[11:8] = q.din_s[3:0];
      end
    end
    // Fast-cycle grant flags any command that this block decodes itself
    n.fcg = (q.rd_s | q.wr_s) & (hit_lo | hit_hi | (|cs_strobe));

    // Pin drive; later assignments win, so chip strobe 0 has top priority
    src1 = 1'b0;
    src2 = 1'b0;
    for (int p = 0; p < gaf_pkg::NUM_PINS; p++) begin
      n.gpio_oe[p] = 1'b0;
      n.gpio_out[p] = pol[p];
      if (func[p]) begin
        n.gpio_oe[p] = ~dir[p]; // [R10] [R11]
        n.gpio_out[p] = q.sio_data[p] ^ pol[p]; // [R9] [R19]
      end else begin
        sel = gaf_pkg::gaf_pin_of(q.share[gaf_pkg::LOC_MSB:gaf_pkg::LOC_LSB]); // [R14]
        if (sel.hit && sel.pin == 4'(p)) begin
          n.gpio_oe[p] = 1'b1;
          n.gpio_out[p] = ~q.fcg ^ pol[p];
        end
        sel = gaf_pkg::gaf_pin_of(q.blink[gaf_pkg::BLINK_LOC_MSB:gaf_pkg::BLINK_LOC_LSB]); // [R8] [R14]
        if (sel.hit && sel.pin == 4'(p)) begin
          n.gpio_oe[p] = 1'b1;
          n.gpio_out[p] = blink_wave ^ pol[p]; // [R7] [R9]
        end
        for (int c = 2; c >= 0; c--) begin
          sel = gaf_pkg::gaf_pin_of(q.cs_ctrl[c][gaf_pkg::LOC_MSB:gaf_pkg::LOC_LSB]); // [R2] [R14]
          if (sel.hit && sel.pin == 4'(p)) begin
            n.gpio_oe[p] = 1'b1;
            n.gpio_out[p] = ~cs_strobe[c] ^ pol[p]; // [R9]
          end
        end
        sel = gaf_pkg::gaf_pin_of(q.irq1[gaf_pkg::ROUTE_LOC_MSB:gaf_pkg::ROUTE_LOC_LSB]); // [R5]
        if (sel.hit && sel.pin == 4'(p)) begin
          src1 = q.pin_s[p] ^ pol[p];
        end
        sel = gaf_pkg::gaf_pin_of(q.irq2[gaf_pkg::ROUTE_LOC_MSB:gaf_pkg::ROUTE_LOC_LSB]); // [R6]
        if (sel.hit && sel.pin == 4'(p)) begin
          src2 = q.pin_s[p] ^ pol[p];
        end
      end
    end

    // Interrupt steering; a shared line is only driven while active
    // so several sources can share one request line
    for (int k = 0; k < gaf_pkg::NUM_IRQ; k++) begin
      n.irq_out[k] = 1'b0;
      n.irq_oe[k] = 1'b0;
      if (gaf_pkg::gaf_irq_ok(q.irq1[3:0]) && q.irq1[3:0] == 4'(k)) begin // [R5]
        lvl = src1;
        n.irq_out[k] = n.irq_out[k] | lvl;
        n.irq_oe[k] = n.irq_oe[k] | (q.share[gaf_pkg::SHARE1_BIT] ? lvl : 1'b1); // [R15]
      end
      if (gaf_pkg::gaf_irq_ok(q.irq2[3:0]) && q.irq2[3:0] == 4'(k)) begin // [R6]
        lvl = src2;
        n.irq_out[k] = n.irq_out[k] | lvl;
        n.irq_oe[k] = n.irq_oe[k] | (q.share[gaf_pkg::SHARE2_BIT] ? lvl : 1'b1); // [R15]
      end
    end
  end

  // ****************************************
  // Register update
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0; // [R13]
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = q.rdata;
  assign io_data_out = q.io_dout;
  assign io_data_oe = q.io_doe;
  assign gpio_out = q.gpio_out;
  assign gpio_oe = q.gpio_oe;
  assign irq_out = q.irq_out;
  assign irq_oe = q.irq_oe;

endmodule
`default_nettype wire
